// ===== verilog/sacl_pkg.sv
// Package for the servo alarm and deviation-clear output block
package sacl_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] SACL_ENV_OFS = 12'h000;
  localparam logic [11:0] SACL_CTL_OFS = 12'h004;
  localparam logic [11:0] SACL_STAT_OFS = 12'h008;

  // ------------------------------------------------------------
  // Field positions in the environment word
  // ------------------------------------------------------------
  localparam int SACL_ALM_STOP_POS = 8;
  localparam int SACL_ALM_POL_POS = 9;
  localparam int SACL_CLR_ABRUPT_POS = 10;
  localparam int SACL_CLR_HOME_POS = 11;
  localparam int SACL_PW_POS = 12;
  localparam logic [31:0] SACL_ENV_RST = 32'h0000_0000;
  localparam logic [31:0] SACL_ENV_MASK = 32'h0000_7f00;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int SACL_CLK_MHZ = 125;
  localparam int SACL_PW0_NS = 12000;
  localparam int SACL_PW1_NS = 102000;
  localparam int SACL_PW2_NS = 409000;
  localparam int SACL_PW3_NS = 1600000;
  localparam int SACL_PW0_CYC = SACL_PW0_NS * SACL_CLK_MHZ / 1000;
  localparam int SACL_PW1_CYC = SACL_PW1_NS * SACL_CLK_MHZ / 1000;
  localparam int SACL_PW2_CYC = SACL_PW2_NS * SACL_CLK_MHZ / 1000;
  localparam int SACL_PW3_CYC = SACL_PW3_NS * SACL_CLK_MHZ / 1000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] clear_pulse_width_sel;
    logic auto_clear_on_home_done;
    logic auto_clear_on_abrupt_stop;
    logic alarm_input_polarity;
    logic alarm_stop_type_sel;
  } sacl_cfg_t;

  typedef struct packed {
    logic end_limit_stop;
    logic alarm_stop;
    logic emergency_stop;
    logic decel_stop;
    logic home_done;
  } sacl_evt_t;

  typedef enum logic [1:0] {
    SACL_STOP_NONE,
    SACL_STOP_ABRUPT,
    SACL_STOP_DECEL
  } sacl_stop_t;

endpackage : sacl_pkg

// ===== verilog/sacl_top.sv
// Servo alarm handling and automatic deviation-clear pulse for one axis
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns

// How it works
// - Bit 8 picks whether an active alarm stops the axis at once (0) or by deceleration (1).
// - Bit 9 sets alarm polarity, 0 meaning low is active and 1 meaning high is active.
// - With bit 10 set, an abrupt stop from end limit, alarm or emergency input fires a clear pulse, except an alarm edge in the cycle of decel_stop_done.
// - A deceleration stop never fires the automatic clear pulse.
// - In feed-to-end-limit mode an abrupt end-limit stop still fires the clear pulse.
// - With bit 11 set, completion of a zero return fires a clear pulse.
// - Width code 000/001/010/011 gives 12 us, 102 us, 409 us or 1.6 ms of clear pulse.
module sacl_top #(
  parameter int PW0_CYC = sacl_pkg::SACL_PW0_CYC,
  parameter int PW1_CYC = sacl_pkg::SACL_PW1_CYC,
  parameter int PW2_CYC = sacl_pkg::SACL_PW2_CYC,
  parameter int PW3_CYC = sacl_pkg::SACL_PW3_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alarm_in,
  input wire logic end_limit_stop,
  input wire logic emergency_stop_in,
  input wire logic decel_stop_done,
  input wire logic home_done,
  input wire logic feed_to_limit_mode,
  output logic alarm_active,
  output sacl_pkg::sacl_stop_t alarm_stop_req,
  output logic deviation_clear_out
);
  import sacl_pkg::*;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [31:0] env_reg, env_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic [1:0] reserved_hits_reg, reserved_hits_next;
  sacl_cfg_t cfg;
  logic setup;
  logic wr_acc;
  logic hits_clr;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  // No wait states: every access completes in two cycles
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg;

  assign cfg.alarm_stop_type_sel = env_reg[SACL_ALM_STOP_POS];
  assign cfg.alarm_input_polarity = env_reg[SACL_ALM_POL_POS];
  assign cfg.auto_clear_on_abrupt_stop = env_reg[SACL_CLR_ABRUPT_POS];
  assign cfg.auto_clear_on_home_done = env_reg[SACL_CLR_HOME_POS];
  assign cfg.clear_pulse_width_sel = env_reg[SACL_PW_POS +: 3];

  // ------------------------------------------------------------
  // Deviation-clear pulse timer
  // ------------------------------------------------------------
  // Wide enough for the longest width at any sensible clock
  logic [31:0] pulse_cnt_reg, pulse_cnt_next;
  logic clear_reg, clear_next;
  logic alarm_q_reg, alarm_q_next;
  logic fire;
  logic width_ok;
  logic alarm_lvl;
  logic [31:0] width_cyc;

  function automatic logic [31:0] width_of(input logic [2:0] code);
    case (code)
      3'h0: width_of = 32'(PW0_CYC);
      3'h1: width_of = 32'(PW1_CYC);
      3'h2: width_of = 32'(PW2_CYC);
      3'h3: width_of = 32'(PW3_CYC);
      // Reserved codes give zero, so no pulse is ever timed
      default: width_of = 32'h0000_0000;
    endcase
  endfunction : width_of

  assign width_cyc = width_of(cfg.clear_pulse_width_sel);
  assign width_ok = (width_cyc != 32'h0000_0000);

  assign alarm_lvl = cfg.alarm_input_polarity ? alarm_in : !alarm_in;
  assign alarm_active = alarm_lvl;

  always_comb begin
    if (!alarm_lvl) begin
      alarm_stop_req = SACL_STOP_NONE;
    end else if (cfg.alarm_stop_type_sel) begin
      alarm_stop_req = SACL_STOP_DECEL;
    end else begin
      alarm_stop_req = SACL_STOP_ABRUPT;
    end
  end

  always_comb begin
    logic abrupt;
    abrupt = 1'b0;
    // abrupt stop sources; limit stop counts even in feed-to-limit mode
    if ((end_limit_stop || feed_to_limit_mode && end_limit_stop) || emergency_stop_in ||
        (alarm_lvl && !alarm_q_reg && !cfg.alarm_stop_type_sel)) begin
      abrupt = 1'b1;
    end
    // deceleration stop never clears
    // Decel and abrupt in one cycle: an end-limit or emergency source wins, an alarm edge is dropped
    if (decel_stop_done) begin
      abrupt = abrupt && (end_limit_stop || emergency_stop_in);
    end
    fire = (abrupt && cfg.auto_clear_on_abrupt_stop) ||
           (home_done && cfg.auto_clear_on_home_done);
  end

  // ------------------------------------------------------------
  // Register bus state
  // ------------------------------------------------------------
  always_comb begin
    env_next = env_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    hits_clr = 1'b0;
    if (wr_acc) begin
      if (paddr == SACL_ENV_OFS) begin
        // Reserved environment bits always read back as zero
        env_next = pwdata & SACL_ENV_MASK;
      end else if (paddr == SACL_CTL_OFS) begin
        hits_clr = pwdata[0];
      end else if (paddr != SACL_STAT_OFS) begin
        err_next = 1'b1;
      end
    end
    // Read data captured at setup; the access phase only presents it
    if (setup) begin
      if (paddr == SACL_ENV_OFS) begin
        rdata_next = env_reg;
      end else if (paddr == SACL_CTL_OFS) begin
        rdata_next = 32'h0000_0000;
      end else if (paddr == SACL_STAT_OFS) begin
        rdata_next = {27'h0, reserved_hits_reg, clear_reg, alarm_lvl, width_ok};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    // Unmapped reads answer zero and flag an error one cycle late
    if (psel && penable && !pwrite && paddr != SACL_ENV_OFS && paddr != SACL_CTL_OFS &&
        paddr != SACL_STAT_OFS) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_reg <= SACL_ENV_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      env_reg <= env_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // ------------------------------------------------------------
  // Clear pulse state
  // ------------------------------------------------------------
  always_comb begin
    reserved_hits_next = reserved_hits_reg;
    pulse_cnt_next = pulse_cnt_reg;
    clear_next = clear_reg;
    // Edge on the active level, so a held alarm fires once
    alarm_q_next = alarm_lvl;
    // Software clear loses to a hit in the same cycle
    if (hits_clr) begin
      reserved_hits_next = 2'h0;
    end
    // A new trigger mid-pulse reloads the full width
    if (clear_reg) begin
      if (pulse_cnt_reg <= 32'h0000_0001) begin
        clear_next = 1'b0;
        pulse_cnt_next = 32'h0000_0000;
      end else begin
        pulse_cnt_next = pulse_cnt_reg - 32'h0000_0001;
      end
    end
    // reserved width code suppresses the pulse
    // Saturating, so software still sees that a hit happened
    if (fire && !width_ok) begin
      reserved_hits_next = (reserved_hits_next == 2'h3) ? 2'h3 : reserved_hits_next + 2'h1;
    end else if (fire) begin
      clear_next = 1'b1;
      pulse_cnt_next = width_cyc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reserved_hits_reg <= 2'h0;
      pulse_cnt_reg <= 32'h0000_0000;
      clear_reg <= 1'b0;
      alarm_q_reg <= 1'b0;
    end else begin
      reserved_hits_reg <= reserved_hits_next;
      pulse_cnt_reg <= pulse_cnt_next;
      clear_reg <= clear_next;
      alarm_q_reg <= alarm_q_next;
    end
  end

  assign deviation_clear_out = clear_reg;

endmodule : sacl_top

// ===== bench/sacl_monitor.sv
// Port-level checks for the alarm and clear-pulse block
`timescale 1ns/1ns
module sacl_monitor #(
  parameter int PW0_CYC = 4,
  parameter int PW1_CYC = 6,
  parameter int PW2_CYC = 8,
  parameter int PW3_CYC = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic alarm_in,
  input wire logic end_limit_stop,
  input wire logic emergency_stop_in,
  input wire logic home_done,
  input wire logic alarm_active,
  input wire sacl_pkg::sacl_stop_t alarm_stop_req,
  input wire logic deviation_clear_out
);
  import sacl_pkg::*;
  logic [6:0] env_reg;
  logic alm_q;
  logic raw;
  logic trig;
  int cnt;
  int wid;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Reserved width codes keep raw causes from firing
  assign raw = (env_reg[2] && (end_limit_stop || emergency_stop_in
    || (alarm_active && !alm_q && !env_reg[0]))) || (env_reg[3] && home_done);
  assign trig = raw && !env_reg[6];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_reg <= '0;
      alm_q <= 1'b0;
      cnt <= 0;
      wid <= 0;
    end else begin
      if (psel && penable && pwrite && paddr == SACL_ENV_OFS) env_reg <= pwdata[14:8];
      alm_q <= alarm_active;
      cnt <= trig ? 0 : cnt + int'(deviation_clear_out);
      if (trig) wid <= env_reg[6:4] == 0 ? PW0_CYC : env_reg[6:4] == 1 ? PW1_CYC
        : env_reg[6:4] == 2 ? PW2_CYC : PW3_CYC;
    end
  end
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_read; psel && !penable && !pwrite && paddr == SACL_ENV_OFS
    |=> prdata == {17'h0, env_reg, 8'h0}; endproperty
  a_read: assert property (p_read) else $error("env read data wrong");
  property p_pol; alarm_active == (alarm_in == env_reg[1]); endproperty
  a_pol: assert property (p_pol) else $error("alarm polarity wrong");
  property p_stop; alarm_stop_req == (!alarm_active ? SACL_STOP_NONE
    : env_reg[0] ? SACL_STOP_DECEL : SACL_STOP_ABRUPT); endproperty
  a_stop: assert property (p_stop) else $error("alarm stop type wrong");
  property p_fire; trig |=> deviation_clear_out; endproperty
  a_fire: assert property (p_fire) else $error("clear pulse missing");
  property p_cause; $rose(deviation_clear_out) |-> $past(trig); endproperty
  a_cause: assert property (p_cause) else $error("clear pulse without cause");
  property p_hold; deviation_clear_out && cnt < wid - 1 |=> deviation_clear_out; endproperty
  a_hold: assert property (p_hold) else $error("clear pulse too short");
  property p_width; $fell(deviation_clear_out) |-> cnt == wid; endproperty
  a_width: assert property (p_width) else $error("clear pulse width wrong");
  c_home: cover property (home_done && trig);
  c_alarm: cover property ($rose(alarm_active) && trig);
  c_long: cover property ($fell(deviation_clear_out) && wid == PW3_CYC);
endmodule : sacl_monitor

// ===== bench/sacl_servo_model.sv
// Servo driver stand-in: alarm source and clear-pulse counter
`timescale 1ns/1ns
module sacl_servo_model (
  input wire logic pclk,
  input wire logic fault,
  input wire logic act_high,
  input wire logic deviation_clear_out,
  output logic alarm_in,
  output int clr_cnt
);
  logic clr_q = 1'b0;
  initial alarm_in = 1'b1;
  initial clr_cnt = 0;
  always @(posedge pclk) begin
    alarm_in <= fault ~^ act_high;
    clr_q <= deviation_clear_out;
    if (deviation_clear_out && !clr_q) clr_cnt <= clr_cnt + 1;
  end
endmodule : sacl_servo_model

// ===== bench/tb_servo_alarm_and_clear_output.sv
// Testbench for the alarm and clear-pulse block
`timescale 1ns/1ns
module tb_servo_alarm_and_clear_output;
  import sacl_pkg::*;
  localparam int PW[4] = '{4, 6, 8, 10};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic act = 1'b1, fm = 1'b0, pready, pslverr, alarm_in, alarm_active, dco;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  sacl_stop_t stop_req;
  sacl_evt_t ev = '0;
  int error_cnt = 0, total_checks = 0, cyc = 0, clr_cnt, n, pulses = 0;
  // Env byte, event, pulse expected
  logic [19:0] tab[11] = '{20'h0a011, 20'h1a011, 20'h2a011, 20'h3a011, 20'h06101,
    20'h06041, 20'h06081, 20'h06020, 20'h07080, 20'h4a010, 20'h02100};
  sacl_top #(.PW0_CYC(PW[0]), .PW1_CYC(PW[1]), .PW2_CYC(PW[2]), .PW3_CYC(PW[3])) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .alarm_in, .end_limit_stop(ev.end_limit_stop),
    .emergency_stop_in(ev.emergency_stop), .decel_stop_done(ev.decel_stop),
    .home_done(ev.home_done), .feed_to_limit_mode(fm), .alarm_active,
    .alarm_stop_req(stop_req), .deviation_clear_out(dco));
  sacl_servo_model srv_u (.pclk, .fault(ev.alarm_stop), .act_high(act),
    .deviation_clear_out(dco), .alarm_in, .clr_cnt);
  initial forever #4 pclk = ~pclk;
  task conclude;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // One-cycle event, then count high cycles of the clear output
  task fire(input logic [4:0] e, output int k);
    k = 0;
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= '0;
    repeat (16) begin
      #1 k += int'(dco === 1'b1);
      @(posedge pclk);
    end
  endtask : fire
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 cmp("alarm_active", 1, alarm_active);
    cmp("stop_req", SACL_STOP_ABRUPT, stop_req);
    xfer(1'b0, SACL_ENV_OFS, '0, q);
    cmp("env_reset", SACL_ENV_RST, q);
    xfer(1'b1, SACL_ENV_OFS, 32'hffff_ffff, q);
    xfer(1'b1, 12'h00c, 32'h0, q);
    #1 cmp("pslverr", 1, pslverr);
    xfer(1'b0, SACL_ENV_OFS, '0, q);
    cmp("env_readback", SACL_ENV_MASK, q);
    #1 cmp("alarm_active", 0, alarm_active);
    cmp("stop_req", SACL_STOP_NONE, stop_req);
    for (int m = 0; m < 2; m++) begin
      fm <= m[0];
      foreach (tab[i]) begin
        xfer(1'b1, SACL_ENV_OFS, {16'h0, tab[i][19:12], 8'h0}, q);
        fire(tab[i][8:4], n);
        pulses += int'(tab[i][0]);
        cmp("clear_width", tab[i][0] ? PW[tab[i][18:16]] : 0, n);
      end
    end
    cmp("pulse_count", pulses, clr_cnt);
    xfer(1'b0, SACL_STAT_OFS, '0, q);
    cmp("status", 32'h0000_0011, q);
    xfer(1'b1, SACL_CTL_OFS, 32'h0000_0001, q);
    #1 cmp("pslverr", 0, pslverr);
    xfer(1'b0, SACL_STAT_OFS, '0, q);
    cmp("status", 32'h0000_0001, q);
    conclude();
  end
endmodule : tb_servo_alarm_and_clear_output
bind sacl_top sacl_monitor #(.PW0_CYC(PW0_CYC), .PW1_CYC(PW1_CYC), .PW2_CYC(PW2_CYC),
  .PW3_CYC(PW3_CYC)) mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .alarm_in, .end_limit_stop, .emergency_stop_in, .home_done,
  .alarm_active, .alarm_stop_req, .deviation_clear_out);
